//--- design/mlgdf_bank.sv
// motor loop gain and drive flag bank with APB slave and auto setup sequencer
//
// Operation
// - the speed feed-forward entry counts tenths of a percent and resets to 1000, a factor of one.
// - the acceleration feed-forward entry resets to zero and zero keeps that feed-forward off.
// - a nonzero acceleration feed-forward acts while decelerating as well as accelerating.
// - a new field inversion value acts only after a restart, after which auto setup must run again.
// - the field inversion byte is signed: 0 default, 1 forced positive, -1 forced negative.
// - with keep-gains at zero, auto setup detects stepper or brushless and loads the matching built-in set.
// - with keep-gains at one, auto setup uses the host gains and leaves them untouched.
// - the open loop torque current gains reset to 0003A980 and 0000AFC8.
// - the closed loop torque current integral gain resets to 00002EE0 and is host read-write.
// - the closed loop position proportional gain resets to 00000800 and is host read-write.
//
// Added by the designer: the APB slave port and the register offsets.
`default_nettype none
module mlgdf_bank
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic motor_is_bldc_i,
   input wire logic accelerating_i,
   input wire logic decelerating_i,
   output mlgdf_pkg::mlgdf_gains_type gains_o,
   output mlgdf_pkg::mlgdf_field_dir_type field_dir_o,
   output logic accel_ff_active_o,
   output logic setup_busy_o,
   output logic setup_needed_o
);
   logic [31:0] gain_q [mlgdf_pkg::GAIN_COUNT];
   logic [7:0] field_inv_q;
   logic [7:0] keep_gains_q;
   logic [7:0] rsvd_flag_q;
   mlgdf_pkg::mlgdf_setup_state_type state_q;
   logic bldc_sync;
   logic bldc_q;

   // APB decode
   wire logic access_w = psel_i && penable_i && !pready_o;
   wire logic commit_w = psel_i && penable_i && pready_o;
   wire logic [5:0] idx_w = paddr_i[7:2];
   wire logic wr_commit_w = commit_w && pwrite_i && !pslverr_o;
   wire logic hit_gain_count_w = idx_w == mlgdf_pkg::IDX_GAIN_COUNT;
   wire logic hit_pos_p_w = idx_w == mlgdf_pkg::IDX_POS_P;
   wire logic hit_gain_hi_w = idx_w >= mlgdf_pkg::IDX_TQ_I_CL && idx_w <= mlgdf_pkg::IDX_AFF;
   wire logic hit_flags_w = idx_w >= mlgdf_pkg::IDX_FLAG_COUNT && idx_w <= mlgdf_pkg::IDX_KEEP_GAINS;
   wire logic hit_ctl_w = idx_w == mlgdf_pkg::IDX_CONTROL;
   wire logic hit_st_w = idx_w == mlgdf_pkg::IDX_STATUS;
   wire logic mapped_w = hit_gain_count_w || hit_pos_p_w || hit_gain_hi_w || hit_flags_w || hit_ctl_w || hit_st_w;
   wire logic restart_w = wr_commit_w && hit_ctl_w && pwdata_i[mlgdf_pkg::CTL_RESTART];
   wire logic setup_go_w = wr_commit_w && hit_ctl_w && pwdata_i[mlgdf_pkg::CTL_SETUP]
      && state_q == mlgdf_pkg::SETUP_IDLE;
   wire logic load_w = state_q == mlgdf_pkg::SETUP_LOAD && keep_gains_q != mlgdf_pkg::KEEP_GAINS;

   mlgdf_sync2 u_bldc_sync
   (
      .sys_clk_i(sys_clk_i),
      .reset_i(reset_i),
      .async_i(motor_is_bldc_i),
      .sync_o(bldc_sync)
   );

   for (genvar g = 0; g < mlgdf_pkg::GAIN_COUNT; g++)
   begin : g_gain
      mlgdf_gain_reg #(.RESET_VALUE(mlgdf_pkg::GAIN_RESET[g])) u_gain
      (
         .sys_clk_i(sys_clk_i),
         .reset_i(reset_i),
         .wr_en_i(wr_commit_w && idx_w == mlgdf_pkg::GAIN_IDX[g]),
         .wr_data_i(pwdata_i),
         .ld_en_i(load_w),
         .ld_data_i(bldc_q ? mlgdf_pkg::BLDC_SET[g] : mlgdf_pkg::STEPPER_SET[g]),
         .value_o(gain_q[g])
      );
   end

   assign gains_o.pos_p = gain_q[mlgdf_pkg::GI_POS_P];
   assign gains_o.tq_i_cl = gain_q[mlgdf_pkg::GI_TQ_I_CL];
   assign gains_o.tq_p_ol = gain_q[mlgdf_pkg::GI_TQ_P_OL];
   assign gains_o.tq_i_ol = gain_q[mlgdf_pkg::GI_TQ_I_OL];
   assign gains_o.vff_permille = gain_q[mlgdf_pkg::GI_VFF];
   assign gains_o.aff = gain_q[mlgdf_pkg::GI_AFF];

   // read data selection
   logic [31:0] gain_rd_w;
   always_comb
   begin
      gain_rd_w = 32'h0000_0000;
      for (int i = 0; i < mlgdf_pkg::GAIN_COUNT; i++)
      begin
         if (idx_w == mlgdf_pkg::GAIN_IDX[i])
            gain_rd_w = gain_q[i];
      end
   end

   wire logic [31:0] status_w = {27'h0, field_dir_o.inverted, field_dir_o.forced, bldc_q,
      setup_busy_o, setup_needed_o};
   wire logic [31:0] rd_data_w =
      hit_gain_count_w ? {24'h0, mlgdf_pkg::GAIN_ENTRY_COUNT} :
      (hit_pos_p_w || hit_gain_hi_w) ? gain_rd_w :
      idx_w == mlgdf_pkg::IDX_FLAG_COUNT ? {24'h0, mlgdf_pkg::FLAG_ENTRY_COUNT} :
      idx_w == mlgdf_pkg::IDX_FLAG_RSVD ? {24'h0, rsvd_flag_q} :
      idx_w == mlgdf_pkg::IDX_FIELD_INV ? {24'h0, field_inv_q} :
      idx_w == mlgdf_pkg::IDX_KEEP_GAINS ? {24'h0, keep_gains_q} :
      hit_st_w ? status_w : 32'h0000_0000;

   // one wait state: pready rises at the edge ending the first access cycle, commit at the edge ending the second
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end
      else
      begin
         pready_o <= access_w;
         pslverr_o <= access_w && !mapped_w;
         prdata_o <= (access_w && !pwrite_i) ? rd_data_w : 32'h0000_0000;
      end
   end

   // drive flag bytes; count entries have no storage so writes fall away
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         rsvd_flag_q <= mlgdf_pkg::FLAG_RESET;
         field_inv_q <= mlgdf_pkg::FLAG_RESET;
         keep_gains_q <= mlgdf_pkg::FLAG_RESET;
      end
      else if (wr_commit_w)
      begin
         if (idx_w == mlgdf_pkg::IDX_FLAG_RSVD)
            rsvd_flag_q <= pwdata_i[7:0];
         else if (idx_w == mlgdf_pkg::IDX_FIELD_INV)
            field_inv_q <= pwdata_i[7:0];
         else if (idx_w == mlgdf_pkg::IDX_KEEP_GAINS)
            keep_gains_q <= pwdata_i[7:0];
      end
   end

   // field direction follows the stored byte only at a controller restart
   wire logic dir_forced_w = field_inv_q == mlgdf_pkg::FIELD_FORCE_POS
      || field_inv_q == mlgdf_pkg::FIELD_FORCE_NEG;
   wire logic dir_inverted_w = field_inv_q == mlgdf_pkg::FIELD_FORCE_NEG;
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         field_dir_o <= '0;
         setup_needed_o <= 1'b0;
      end
      else
      begin
         if (restart_w)
         begin
            field_dir_o.forced <= dir_forced_w;
            field_dir_o.inverted <= dir_inverted_w;
         end
         // a restart in the finishing cycle still demands a fresh setup
         if (restart_w)
            setup_needed_o <= 1'b1;
         else if (state_q == mlgdf_pkg::SETUP_DONE)
            setup_needed_o <= 1'b0;
      end
   end

   // auto setup: sample motor type, then load a built-in set or keep host gains
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         state_q <= mlgdf_pkg::SETUP_IDLE;
         bldc_q <= 1'b0;
         setup_busy_o <= 1'b0;
      end
      else
      begin
         case (state_q)
            mlgdf_pkg::SETUP_IDLE:
               if (setup_go_w)
               begin
                  state_q <= mlgdf_pkg::SETUP_LOAD;
                  bldc_q <= bldc_sync;
                  setup_busy_o <= 1'b1;
               end
            mlgdf_pkg::SETUP_LOAD:
               state_q <= mlgdf_pkg::SETUP_DONE;
            mlgdf_pkg::SETUP_DONE:
            begin
               state_q <= mlgdf_pkg::SETUP_IDLE;
               setup_busy_o <= 1'b0;
            end
            default:
               state_q <= mlgdf_pkg::SETUP_IDLE;
         endcase
      end
   end

   // feed-forward acts in both directions of speed change, never at zero
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         accel_ff_active_o <= 1'b0;
      else
         accel_ff_active_o <= gain_q[mlgdf_pkg::GI_AFF] != 32'h0000_0000
            && (accelerating_i || decelerating_i);
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   // auto setup steps, shared by the setup properties
   sequence s_setup_start;
      setup_go_w;
   endsequence
   sequence s_setup_load;
      state_q == mlgdf_pkg::SETUP_LOAD ##1 state_q == mlgdf_pkg::SETUP_DONE;
   endsequence
   sequence s_busy_two;
      setup_busy_o ##1 setup_busy_o ##1 !setup_busy_o;
   endsequence

   a_vff_reset_unity: assert property ($fell(reset_i) |-> gain_q[mlgdf_pkg::GI_VFF] == mlgdf_pkg::VFF_UNITY)
      else $error("speed feed-forward did not reset to unity");
   a_aff_zero_off: assert property (gain_q[mlgdf_pkg::GI_AFF] == 32'h0000_0000 |=> !accel_ff_active_o)
      else $error("acceleration feed-forward active at zero factor");
   a_aff_decel_on: assert property (gain_q[mlgdf_pkg::GI_AFF] != 32'h0000_0000 && decelerating_i
      |=> accel_ff_active_o)
      else $error("acceleration feed-forward missing while decelerating");
   a_aff_accel_on: assert property (gain_q[mlgdf_pkg::GI_AFF] != 32'h0000_0000 && accelerating_i
      |=> accel_ff_active_o)
      else $error("acceleration feed-forward missing while accelerating");
   a_dir_needs_restart: assert property (!restart_w |=> $stable(field_dir_o))
      else $error("field direction changed without restart");
   a_restart_needs_setup: assert property (restart_w |=> setup_needed_o)
      else $error("restart did not demand auto setup");
   a_setup_clears_need: assert property (state_q == mlgdf_pkg::SETUP_DONE && !restart_w |=> !setup_needed_o)
      else $error("finished auto setup left the demand standing");
   a_dir_decode_neg: assert property (restart_w && field_inv_q == mlgdf_pkg::FIELD_FORCE_NEG
      |=> field_dir_o.forced && field_dir_o.inverted)
      else $error("minus one did not force inverted field");
   a_dir_decode_pos: assert property (restart_w && field_inv_q == mlgdf_pkg::FIELD_FORCE_POS
      |=> field_dir_o.forced && !field_dir_o.inverted)
      else $error("one did not force positive field");
   a_dir_decode_dflt: assert property (restart_w && field_inv_q == mlgdf_pkg::FIELD_DEFAULT
      |=> !field_dir_o.forced)
      else $error("zero did not select default field");
   a_setup_loads_set: assert property (s_setup_start ##0 (keep_gains_q == mlgdf_pkg::FLAG_RESET
      && !$changed(keep_gains_q)) ##1 s_setup_load |-> gain_q[mlgdf_pkg::GI_POS_P] ==
      (bldc_q ? mlgdf_pkg::BLDC_SET[mlgdf_pkg::GI_POS_P] : mlgdf_pkg::STEPPER_SET[mlgdf_pkg::GI_POS_P]))
      else $error("auto setup did not load the built-in set");
   a_setup_busy_span: assert property (s_setup_start |=> s_busy_two)
      else $error("auto setup busy span wrong");
   a_motor_sampled: assert property (s_setup_start |=> bldc_q == $past(bldc_sync))
      else $error("motor type not sampled at setup start");
   a_setup_keeps_gains: assert property (state_q == mlgdf_pkg::SETUP_LOAD
      && keep_gains_q == mlgdf_pkg::KEEP_GAINS && !wr_commit_w |=> $stable(gain_q[mlgdf_pkg::GI_TQ_I_CL]))
      else $error("auto setup touched kept gains");
   a_keep_all_gains: assert property (state_q == mlgdf_pkg::SETUP_LOAD
      && keep_gains_q == mlgdf_pkg::KEEP_GAINS && !wr_commit_w |=> $stable(gains_o))
      else $error("auto setup changed a kept gain entry");
   // reset values seen at the first edge out of reset
   a_ol_gain_reset: assert property ($fell(reset_i)
      |-> gain_q[mlgdf_pkg::GI_TQ_P_OL] == 32'h0003_A980 && gain_q[mlgdf_pkg::GI_TQ_I_OL] == 32'h0000_AFC8)
      else $error("open loop gains reset wrong");
   a_cl_gain_reset: assert property ($fell(reset_i)
      |-> gain_q[mlgdf_pkg::GI_TQ_I_CL] == 32'h0000_2EE0 && gain_q[mlgdf_pkg::GI_POS_P] == 32'h0000_0800)
      else $error("closed loop gains reset wrong");
   a_tq_cl_write: assert property (wr_commit_w && idx_w == mlgdf_pkg::IDX_TQ_I_CL
      && state_q != mlgdf_pkg::SETUP_LOAD |=> gain_q[mlgdf_pkg::GI_TQ_I_CL] == $past(pwdata_i))
      else $error("closed loop integral gain write lost");
   a_pos_p_write: assert property (wr_commit_w && idx_w == mlgdf_pkg::IDX_POS_P
      && state_q != mlgdf_pkg::SETUP_LOAD |=> gain_q[mlgdf_pkg::GI_POS_P] == $past(pwdata_i))
      else $error("position gain write lost");
   a_count_fixed: assert property (access_w && !pwrite_i && hit_gain_count_w
      |=> prdata_o == 32'h0000_000C ##1 !pready_o)
      else $error("entry count read wrong");
   a_flag_count_fixed: assert property (access_w && !pwrite_i && idx_w == mlgdf_pkg::IDX_FLAG_COUNT
      |=> prdata_o == {24'h00_0000, mlgdf_pkg::FLAG_ENTRY_COUNT})
      else $error("flag entry count read wrong");
   // bus answer shape: one wait state, a one-cycle answer, zero data outside it
   a_ready_after_wait: assert property (access_w |=> pready_o)
      else $error("no ready after the wait state");
   a_ready_one_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready held longer than one cycle");
   a_err_with_ready: assert property (pslverr_o |-> pready_o)
      else $error("error flag without ready");
   a_rdata_idle_zero: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
      else $error("read data not zero outside the answer");
endmodule : mlgdf_bank
`default_nettype wire

//--- design/mlgdf_gain_reg.sv
// one 32-bit gain entry, host write or auto setup load
`default_nettype none
module mlgdf_gain_reg
#(
   parameter logic [31:0] RESET_VALUE = 32'h0000_0000
)
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic wr_en_i,
   input wire logic [31:0] wr_data_i,
   input wire logic ld_en_i,
   input wire logic [31:0] ld_data_i,
   output logic [31:0] value_o
);
   // auto setup load wins over a host write in the same cycle
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         value_o <= RESET_VALUE;
      else if (ld_en_i)
         value_o <= ld_data_i;
      else if (wr_en_i)
         value_o <= wr_data_i;
   end
endmodule : mlgdf_gain_reg
`default_nettype wire

//--- design/mlgdf_pkg.sv
// package: register map, reset values and carrier types of the motor loop gain bank
`default_nettype none
package mlgdf_pkg;
   localparam int unsigned GAIN_COUNT = 6;
   // gain slots inside the bank
   localparam int unsigned GI_POS_P = 0;
   localparam int unsigned GI_TQ_I_CL = 1;
   localparam int unsigned GI_TQ_P_OL = 2;
   localparam int unsigned GI_TQ_I_OL = 3;
   localparam int unsigned GI_VFF = 4;
   localparam int unsigned GI_AFF = 5;
   // word indices, byte address is four times the index
   localparam logic [5:0] IDX_GAIN_COUNT = 6'h00;
   localparam logic [5:0] IDX_POS_P = 6'h01;
   localparam logic [5:0] IDX_TQ_I_CL = 6'h08;
   localparam logic [5:0] IDX_TQ_P_OL = 6'h09;
   localparam logic [5:0] IDX_TQ_I_OL = 6'h0A;
   localparam logic [5:0] IDX_VFF = 6'h0B;
   localparam logic [5:0] IDX_AFF = 6'h0C;
   localparam logic [5:0] IDX_FLAG_COUNT = 6'h10;
   localparam logic [5:0] IDX_FLAG_RSVD = 6'h11;
   localparam logic [5:0] IDX_FIELD_INV = 6'h12;
   localparam logic [5:0] IDX_KEEP_GAINS = 6'h13;
   localparam logic [5:0] IDX_CONTROL = 6'h20;
   localparam logic [5:0] IDX_STATUS = 6'h21;
   localparam logic [5:0] GAIN_IDX [GAIN_COUNT] = '{6'h01, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C};
   // reset values
   localparam logic [31:0] GAIN_RESET [GAIN_COUNT] =
      '{32'h0000_0800, 32'h0000_2EE0, 32'h0003_A980, 32'h0000_AFC8, 32'h0000_03E8, 32'h0000_0000};
   localparam logic [31:0] VFF_UNITY = 32'h0000_03E8;
   localparam logic [7:0] GAIN_ENTRY_COUNT = 8'h0C;
   localparam logic [7:0] FLAG_ENTRY_COUNT = 8'h03;
   localparam logic [7:0] FLAG_RESET = 8'h00;
   // signed byte codes of the field direction override
   localparam logic [7:0] FIELD_DEFAULT = 8'h00;
   localparam logic [7:0] FIELD_FORCE_POS = 8'h01;
   localparam logic [7:0] FIELD_FORCE_NEG = 8'hFF;
   localparam logic [7:0] KEEP_GAINS = 8'h01;
   // built-in sets loaded by auto setup; feed-forward slots are loaded with their reset values
   localparam logic [31:0] STEPPER_SET [GAIN_COUNT] =
      '{32'h0000_0800, 32'h0000_2EE0, 32'h0003_A980, 32'h0000_AFC8, 32'h0000_03E8, 32'h0000_0000};
   localparam logic [31:0] BLDC_SET [GAIN_COUNT] =
      '{32'h0000_1000, 32'h0000_1770, 32'h0003_A980, 32'h0000_AFC8, 32'h0000_03E8, 32'h0000_0000};
   // control and status bits
   localparam int unsigned CTL_RESTART = 0;
   localparam int unsigned CTL_SETUP = 1;
   localparam int unsigned ST_NEEDED = 0;
   localparam int unsigned ST_BUSY = 1;
   localparam int unsigned ST_BLDC = 2;
   localparam int unsigned ST_FORCED = 3;
   localparam int unsigned ST_INVERTED = 4;

   typedef struct packed {
      logic forced;
      logic inverted;
   } mlgdf_field_dir_type;

   typedef struct packed {
      logic [31:0] pos_p;
      logic [31:0] tq_i_cl;
      logic [31:0] tq_p_ol;
      logic [31:0] tq_i_ol;
      logic [31:0] vff_permille;
      logic [31:0] aff;
   } mlgdf_gains_type;

   typedef enum logic [2:0] {
      SETUP_IDLE = 3'b001,
      SETUP_LOAD = 3'b010,
      SETUP_DONE = 3'b100
   } mlgdf_setup_state_type;
endpackage : mlgdf_pkg
`default_nettype wire

//--- design/mlgdf_sync2.sv
// two-stage synchroniser for one level from a pin
`default_nettype none
module mlgdf_sync2
(
   input wire logic sys_clk_i,
   input wire logic reset_i,
   input wire logic async_i,
   output logic sync_o
);
   logic meta_q;

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         meta_q <= 1'b0;
         sync_o <= 1'b0;
      end
      else
      begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule : mlgdf_sync2
`default_nettype wire

//--- tb/mlgdf_host.sv
// host model: APB master that reaches the parameter bank
`default_nettype none
module mlgdf_host
(
   input wire logic sys_clk_i,
   input wire logic pready_i,
   input wire logic pslverr_i,
   input wire logic [31:0] prdata_i,
   output logic psel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [7:0] paddr_o,
   output logic [31:0] pwdata_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 8'h00;
      pwdata_o = 32'h0000_0000;
   end

   // one whole transfer; no answer latency is assumed
   task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge sys_clk_i);
      psel_o <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o <= wr;
      paddr_o <= {idx, 2'b00};
      pwdata_o <= wd;
      @(posedge sys_clk_i);
      penable_o <= 1'b1;
      // a silent slave is ended by the bench watchdog, not here
      do
         @(posedge sys_clk_i);
      while (pready_i !== 1'b1);
      rd = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      // released lines change so that stale values are never trusted
      paddr_o <= ~paddr_o;
      pwdata_o <= ~pwdata_o;
   endtask : xfer
endmodule : mlgdf_host
`default_nettype wire

//--- tb/tb.sv
// testbench: bank driven through the host model, compared with a reference model
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i;
   logic reset_i;
   logic psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, x;
   logic motor_is_bldc, accelerating, decelerating, accel_ff_active, setup_busy, setup_needed;
   mlgdf_pkg::mlgdf_gains_type gains;
   mlgdf_pkg::mlgdf_field_dir_type field_dir;
   logic [31:0] mdl [int];
   logic [5:0] idx_list [11] = '{6'h00, 6'h01, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h10, 6'h11, 6'h12, 6'h13};
   logic [7:0] fcode [4] = '{8'h00, 8'h01, 8'hFF, 8'h05};
   logic [1:0] fexp [4] = '{2'b00, 2'b10, 2'b11, 2'b00};
   logic [1:0] fprev;
   int n_fail;
   int cmp_count;
   int i;
   int j;

   initial
   begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end

   mlgdf_bank mlgdf_bank_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .motor_is_bldc_i(motor_is_bldc), .accelerating_i(accelerating),
      .decelerating_i(decelerating), .gains_o(gains), .field_dir_o(field_dir),
      .accel_ff_active_o(accel_ff_active), .setup_busy_o(setup_busy), .setup_needed_o(setup_needed));

   mlgdf_host mlgdf_host_i (.sys_clk_i(sys_clk_i), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
      .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      mlgdf_host_i.xfer(1'b1, idx, d, x, err);
      chk("write error", {31'h0, err}, 32'h0);
   endtask : wr

   task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
      mlgdf_host_i.xfer(1'b0, idx, ~exp, rd, err);
      chk("read data", rd, exp);
      chk("read error", {31'h0, err}, 32'h0);
   endtask : rdchk

   task automatic put(input logic [5:0] idx, input logic [31:0] d);
      wr(idx, d);
      if (idx >= 6'h11)
         mdl[idx] = {24'h0, d[7:0]};
      else if (idx != 6'h00 && idx != 6'h10)
         mdl[idx] = d;
   endtask : put

   task automatic chk_gains();
      for (int k = 0; k < mlgdf_pkg::GAIN_COUNT; k++)
         chk("gains", gains[191 - 32 * k -: 32], mdl[mlgdf_pkg::GAIN_IDX[k]]);
   endtask : chk_gains

   task automatic model_reset();
      mdl[6'h01] = 32'h0000_0800;
      mdl[6'h08] = 32'h0000_2EE0;
      mdl[6'h09] = 32'h0003_A980;
      mdl[6'h0A] = 32'h0000_AFC8;
      mdl[6'h0B] = 32'h0000_03E8;
      mdl[6'h0C] = 32'h0000_0000;
   endtask : model_reset

   task automatic run_setup();
      int n;
      wr(mlgdf_pkg::IDX_CONTROL, 32'h0000_0002);
      n = 0;
      while (setup_busy !== 1'b1 && n < 10)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      while (setup_busy === 1'b1 && n < 20)
      begin
         @(posedge sys_clk_i);
         n++;
      end
      chk("setup end", {31'h0, setup_busy | setup_needed}, 32'h0);
   endtask : run_setup

   task automatic print_verdict();
      if (n_fail == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   initial
   begin
      repeat (20000) @(posedge sys_clk_i);
      n_fail++;
      print_verdict();
   end

   initial
   begin
      n_fail = 0;
      cmp_count = 0;
      reset_i = 1'b1;
      motor_is_bldc = 1'b1;
      accelerating = 1'b0;
      decelerating = 1'b0;
      fprev = 2'b00;
      void'($urandom(32'h112135B7));
      model_reset();
      mdl[6'h00] = 32'h0000_000C;
      mdl[6'h10] = 32'h0000_0003;
      mdl[6'h11] = 32'h0000_0000;
      mdl[6'h12] = 32'h0000_0000;
      mdl[6'h13] = 32'h0000_0000;
      repeat (20) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      foreach (idx_list[k]) rdchk(idx_list[k], mdl[idx_list[k]]);
      chk_gains();
      // random host values everywhere; the count fields must not move
      foreach (idx_list[k]) put(idx_list[k], $urandom());
      foreach (idx_list[k]) rdchk(idx_list[k], mdl[idx_list[k]]);
      chk_gains();
      mlgdf_host_i.xfer(1'b1, 6'h03, 32'h1234_5678, rd, err);
      chk("unmapped error", {31'h0, err}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      // keep the host gains while the field direction codes are cycled through restarts
      put(mlgdf_pkg::IDX_KEEP_GAINS, 32'h0000_0001);
      for (i = 0; i < 4; i++)
      begin
         put(mlgdf_pkg::IDX_FIELD_INV, {24'h0, fcode[i]});
         repeat (3) @(posedge sys_clk_i);
         chk("dir before restart", {30'h0, field_dir}, {30'h0, fprev});
         wr(mlgdf_pkg::IDX_CONTROL, 32'h0000_0001);
         repeat (2) @(posedge sys_clk_i);
         chk("dir after restart", {30'h0, field_dir}, {30'h0, fexp[i]});
         chk("setup needed", {31'h0, setup_needed}, 32'h1);
         fprev = fexp[i];
         run_setup();
         chk_gains();
      end
      // built-in sets for both motor types
      put(mlgdf_pkg::IDX_KEEP_GAINS, 32'h0000_0000);
      run_setup();
      model_reset();
      for (i = 0; i < 2; i++)
         mdl[mlgdf_pkg::GAIN_IDX[i]] = mlgdf_pkg::BLDC_SET[i];
      chk_gains();
      rdchk(mlgdf_pkg::IDX_POS_P, mdl[6'h01]);
      rdchk(mlgdf_pkg::IDX_STATUS, 32'h0000_0001 << mlgdf_pkg::ST_BLDC);
      rdchk(mlgdf_pkg::IDX_CONTROL, 32'h0000_0000);
      put(mlgdf_pkg::IDX_POS_P, $urandom());
      motor_is_bldc <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      run_setup();
      model_reset();
      chk_gains();
      rdchk(mlgdf_pkg::IDX_STATUS, 32'h0000_0000);
      // feed-forward activity over every motion combination, off and on
      for (j = 0; j < 2; j++)
      begin
         for (i = 0; i < 4; i++)
         begin
            @(posedge sys_clk_i);
            {accelerating, decelerating} <= i[1:0];
            repeat (3) @(posedge sys_clk_i);
            chk("accel ff", {31'h0, accel_ff_active}, {31'h0, j == 1 && i != 0});
         end
         put(mlgdf_pkg::IDX_AFF, $urandom() | 32'h0000_0001);
      end
      print_verdict();
   end
endmodule : tb
`default_nettype wire
